/* test/csfm_chk.sv */
// Port checker for the clock switch block
`timescale 1ns/1ns
`default_nettype none
module csfm_chk
    import csfm_pkg::*;
(
    input wire logic         aclk,
    input wire logic         aresetn,
    input wire logic         s_axi_awready,
    input wire logic         s_axi_wvalid,
    input wire logic         s_axi_bvalid,
    input wire logic         s_axi_arready,
    input wire logic         s_axi_rvalid,
    input wire logic         failsafe_clock_monitor,
    input wire logic         switch_done,
    input wire csfm_switch_t switch_cmd,
    input wire logic         osc_fail_trap
);
    wire logic req = switch_cmd.req;
    logic [3:0] wv_ff;
    // A write must lie within the last four edges of a request rise or a flag fall
    always_ff @(posedge aclk) wv_ff <= {wv_ff[2:0], s_axi_wvalid};
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_FAIL_TRAP: assert property (
        $rose(failsafe_clock_monitor) |-> ##[1:6] osc_fail_trap) else $error("trap late");
    AST_REQ_DONE: assert property (
        req && $rose(switch_done) |-> ##[1:6] !req) else $error("request stuck");
    AST_REQ_HOLD: assert property (
        (req && !switch_done) [*4] |=> req) else $error("request dropped early");
    AST_SRC_HOLD: assert property (
        req && $past(req) |-> $stable(switch_cmd.src)) else $error("source moved");
    AST_REQ_CAUSE: assert property ($rose(req) |-> |wv_ff)
        else $error("request without write");
    AST_FLAG_CLEAR: assert property ($fell(osc_fail_trap) |-> |wv_ff)
        else $error("flag cleared by hardware");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken during response");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
    cover property ($rose(osc_fail_trap));
    cover property ($fell(req));
    cover property (s_axi_bvalid);
endmodule : csfm_chk
bind csfm_top csfm_chk u_csfm_chk (.*);
`default_nettype wire

/* test/csfm_osc_model.sv */
// Oscillator side model: answers switches after a set delay and injects failures
`timescale 1ns/1ns
`default_nettype none
module csfm_osc_model
    import csfm_pkg::*;
(
    input wire logic         aclk,
    input wire logic         aresetn,
    input wire csfm_switch_t switch_cmd,
    input wire logic [7:0]   dly,
    input wire logic         fail_inj,
    output logic             switch_done,
    output logic             failsafe_clock_monitor
);
    logic [7:0] cnt_ff;
    // Done is held until the request drops, so the synchroniser cannot miss it
    always_ff @(posedge aclk) begin
        if (!aresetn || !switch_cmd.req) begin
            cnt_ff <= 8'h00;
            switch_done <= 1'h0;
        end else if (cnt_ff != dly) begin
            cnt_ff <= cnt_ff + 8'h01;
        end else begin
            switch_done <= 1'h1;
        end
        failsafe_clock_monitor <= fail_inj && aresetn;
    end
endmodule : csfm_osc_model
`default_nettype wire

/* test/tb_clock_switch_fail_monitor.sv */
// Self-checking bench for the clock switch block
`timescale 1ns/1ns
`default_nettype none
`include "csfm_regs.svh"
module tb_clock_switch_fail_monitor
    import csfm_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic failsafe_clock_monitor, switch_done, osc_fail_trap, fail_inj;
    logic [11:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0]  s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0]   s_axi_wstrb;
    logic [1:0]   s_axi_bresp, s_axi_rresp, rs;
    logic [7:0]   dly;
    csfm_switch_t switch_cmd;
    int           error_cnt = 0, checks_done = 0, cyc = 0;
    csfm_top u_csfm_top (.*);
    csfm_osc_model u_csfm_osc_model (.*);
    initial begin
        aclk = 1'h0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    // One transfer; a ready seen while idle only re-lowers an already low valid
    task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        if (w) begin
            {s_axi_awaddr, s_axi_wdata} <= {a, d};
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        end else begin
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
        end
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_bvalid || s_axi_rvalid) begin
                {rdv, rs} = w ? {32'h0, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
                {s_axi_bready, s_axi_rready} <= 2'h0;
                break;
            end
        end
    endtask : xf
    task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        xf(1'h0, a, 32'h0);
        chk(rdv & m, e);
    endtask : rc
    task automatic cw(input logic [31:0] d);
        xf(1'h1, `CSFM_OFS_UNLOCK, 32'(`CSFM_UNLOCK_KEY1));
        xf(1'h1, `CSFM_OFS_UNLOCK, 32'(`CSFM_UNLOCK_KEY2));
        xf(1'h1, `CSFM_OFS_CTRL, d);
    endtask : cw
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, fail_inj, dly} = {56'h0, 4'hF, 9'h0};
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rc(`CSFM_OFS_CTRL, 32'hFFFFFFFF, 32'(`CSFM_CTRL_RST));
        rc(12'h020, 32'hFFFFFFFF, 32'h0);
        chk(rs, 2'h2);
        xf(1'h1, `CSFM_OFS_MASK, 32'h7);
        chk(rs, 2'h0);
        xf(1'h1, `CSFM_OFS_CTRL, 32'h309);
        rc(`CSFM_OFS_CTRL, 32'hFFFF, 32'h0);
        chk(switch_cmd, 4'h0);
        chk(irq, 1'h1);
        rc(`CSFM_OFS_STATUS, 32'hFFFF, 32'h4);
        chk(irq, 1'h0);
        // Slow then prompt answer; the sources avoid a direct move between PLL modes
        for (int i = 0; i < 2; i++) begin
            dly <= (i == 0) ? 8'h14 : 8'h01;
            cw({21'h0, 3'(5 - 4 * i), 8'h17});
            repeat (2) @(posedge aclk);
            chk(switch_cmd, {1'h1, 3'(5 - 4 * i)});
            for (int n = 0; n < 200 && switch_cmd.req; n++) @(posedge aclk);
            rc(`CSFM_OFS_CTRL, 32'hFFF, {21'h0, 3'(5 - 4 * i), 8'h00});
            rc(`CSFM_OFS_CURSRC, 32'hFFFFFFFF, 32'(5 - 4 * i));
            rc(`CSFM_OFS_STATUS, 32'hFFFF, 32'h2);
        end
        // Mask the fail event so the interrupt must stay low while the flag rises
        xf(1'h1, `CSFM_OFS_MASK, 32'h2);
        chk(rs, 2'h0);
        fail_inj <= 1'h1;
        repeat (8) @(posedge aclk);
        chk(osc_fail_trap, 1'h1);
        chk(irq, 1'h0);
        fail_inj <= 1'h0;
        rc(`CSFM_OFS_CTRL, 32'h8, 32'h8);
        rc(`CSFM_OFS_STATUS, 32'hFFFF, 32'h1);
        cw(32'h0);
        rc(`CSFM_OFS_CTRL, 32'h8, 32'h0);
        chk(osc_fail_trap, 1'h0);
        xf(1'h1, `CSFM_OFS_MASK, 32'h1);
        chk(rs, 2'h0);
        cw(32'h8);
        repeat (3) @(posedge aclk);
        chk(osc_fail_trap, 1'h1);
        chk(irq, 1'h1);
        rc(`CSFM_OFS_STATUS, 32'hFFFF, 32'h1);
        // Keys given but the window left to lapse: the clearing write must be dropped
        xf(1'h1, `CSFM_OFS_UNLOCK, 32'(`CSFM_UNLOCK_KEY1));
        xf(1'h1, `CSFM_OFS_UNLOCK, 32'(`CSFM_UNLOCK_KEY2));
        repeat (`CSFM_UNLOCK_CYC + 2) @(posedge aclk);
        xf(1'h1, `CSFM_OFS_CTRL, 32'h0);
        rc(`CSFM_OFS_CTRL, 32'h8, 32'h8);
        chk(osc_fail_trap, 1'h1);
        rc(`CSFM_OFS_STATUS, 32'hFFFF, 32'h4);
        close_out();
    end
endmodule : tb_clock_switch_fail_monitor
`default_nettype wire

/* verilog/csfm_pkg.sv */
// Types shared by the clock switch block
package csfm_pkg;
    typedef enum logic [1:0] {
        csfm_idle,
        csfm_key1,
        csfm_open
    } csfm_lock_t;

    typedef struct packed {
        logic       req;
        logic [2:0] src;
    } csfm_switch_t;
endpackage : csfm_pkg

/* verilog/csfm_regs.svh */
// Register offsets, field positions, reset values and timing counts for the clock switch block
// Summary of operation
// - Monitor failure sets clock fail flag bit 3
// - Software writing flag 1 mimics real failure
// - Switch request bit 0 pending until complete
// - Control writes accepted only after unlock sequence
// - Bits 4 and 2:1 read zero
`ifndef CSFM_REGS_SVH
`define CSFM_REGS_SVH
`define CSFM_OFS_CTRL     12'h000
`define CSFM_OFS_UNLOCK   12'h004
`define CSFM_OFS_STATUS   12'h008
`define CSFM_OFS_MASK     12'h00C
`define CSFM_OFS_CURSRC   12'h010
`define CSFM_BIT_REQ      0
`define CSFM_BIT_FAIL     3
`define CSFM_NEW_SOURCE_SELECT_LSB     8
`define CSFM_COSC_LSB     12
`define CSFM_UNLOCK_KEY1  16'h0055
`define CSFM_UNLOCK_KEY2  16'h00AA
`define CSFM_UNLOCK_NS    1000
`define CSFM_CLK_NS       100
`define CSFM_UNLOCK_CYC   ((`CSFM_UNLOCK_NS) / (`CSFM_CLK_NS))
`define CSFM_CTRL_RST     16'h0000
`define CSFM_ST_FAIL      0
`define CSFM_ST_DONE      1
`define CSFM_ST_DROP      2
`endif

/* verilog/csfm_top.sv */
// Oscillator control register, clock fail flag and switch handshake behind AXI4-Lite
`timescale 1ns/1ns
`default_nettype none
`include "csfm_regs.svh"
module csfm_top
    import csfm_pkg::*;
#(
    parameter int UNLOCK_CYC = `CSFM_UNLOCK_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        failsafe_clock_monitor,
    input  wire logic        switch_done,
    output csfm_switch_t     switch_cmd,
    output logic             osc_fail_trap,
    output logic             irq
);
    // Bus write and read channel capture
    logic        aw_ff, nxt_aw, w_ff, nxt_w, b_ff, nxt_b;
    logic [11:0] awa_ff, nxt_awa;
    logic [31:0] wd_ff, nxt_wd;
    logic [3:0]  ws_ff, nxt_ws;
    logic        r_ff, nxt_r;
    logic [31:0] rd_ff, nxt_rd;
    logic [1:0]  br_ff, nxt_br, rr_ff, nxt_rr;
    // Block state
    logic        fail_ff, nxt_fail, req_ff, nxt_req;
    logic [2:0]  new_source_select_ff, nxt_new_source_select, cosc_ff, nxt_cosc;
    logic [2:0]  st_ff, nxt_st, msk_ff, nxt_msk;
    logic [1:0]  mon_sync_ff, done_sync_ff;
    logic        mon_q_ff, done_q_ff;
    logic        unlocked, wr_go, rd_go, ctrl_wr, key_wr, ctrl_ok;
    logic        fail_ev, done_ev, rd_status;
    logic [15:0] ctrl_view;

    function automatic logic mapped(input logic [11:0] a);
        mapped = a == `CSFM_OFS_CTRL || a == `CSFM_OFS_UNLOCK || a == `CSFM_OFS_STATUS
              || a == `CSFM_OFS_MASK || a == `CSFM_OFS_CURSRC;
    endfunction : mapped

    csfm_unlock #(
        .WINDOW_CYC (UNLOCK_CYC)
    ) u_unlock (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .key_wr   (key_wr),
        .key_data (wd_ff[15:0]),
        .ctrl_wr  (ctrl_wr),
        .unlocked (unlocked)
    );

    assign s_axi_awready = !aw_ff && !b_ff;
    assign s_axi_wready  = !w_ff && !b_ff;
    assign s_axi_arready = !r_ff;
    assign s_axi_bvalid  = b_ff;
    assign s_axi_bresp   = br_ff;
    assign s_axi_rvalid  = r_ff;
    assign s_axi_rdata   = rd_ff;
    assign s_axi_rresp   = rr_ff;

    assign wr_go     = aw_ff && w_ff && !b_ff;
    assign ctrl_wr   = wr_go && awa_ff == `CSFM_OFS_CTRL && ws_ff[0];
    assign key_wr    = wr_go && awa_ff == `CSFM_OFS_UNLOCK && ws_ff[0];
    assign ctrl_ok   = ctrl_wr && unlocked;
    assign rd_go     = s_axi_arvalid && s_axi_arready;
    assign rd_status = rd_go && s_axi_araddr == `CSFM_OFS_STATUS;
    assign fail_ev   = mon_sync_ff[1] && !mon_q_ff;
    assign done_ev   = done_sync_ff[1] && !done_q_ff;

    // Unimplemented bits stay zero in the view
    always_comb begin
        ctrl_view = 16'h0000;
        ctrl_view[`CSFM_BIT_REQ] = req_ff;
        ctrl_view[`CSFM_BIT_FAIL] = fail_ff;
        ctrl_view[`CSFM_NEW_SOURCE_SELECT_LSB +: 3] = new_source_select_ff;
        ctrl_view[`CSFM_COSC_LSB +: 3] = cosc_ff;
    end

    always_comb begin
        nxt_aw   = aw_ff;
        nxt_awa  = awa_ff;
        nxt_w    = w_ff;
        nxt_wd   = wd_ff;
        nxt_ws   = ws_ff;
        nxt_b    = b_ff;
        nxt_br   = br_ff;
        nxt_r    = r_ff;
        nxt_rd   = rd_ff;
        nxt_rr   = rr_ff;
        nxt_fail = fail_ff;
        nxt_req  = req_ff;
        nxt_new_source_select = new_source_select_ff;
        nxt_cosc = cosc_ff;
        nxt_st   = st_ff;
        nxt_msk  = msk_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw  = 1'b1;
            nxt_awa = {s_axi_awaddr[11:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w  = 1'b1;
            nxt_wd = s_axi_wdata;
            nxt_ws = s_axi_wstrb;
        end
        if (wr_go) begin
            nxt_aw = 1'b0;
            nxt_w  = 1'b0;
            nxt_b  = 1'b1;
            nxt_br = mapped(awa_ff) ? 2'b00 : 2'b10;
        end else if (b_ff && s_axi_bready) begin
            nxt_b = 1'b0;
        end
        if (wr_go && awa_ff == `CSFM_OFS_MASK && ws_ff[0]) begin
            nxt_msk = wd_ff[2:0];
        end
        if (done_ev && req_ff) begin
            nxt_req  = 1'b0;
            nxt_cosc = new_source_select_ff;
        end
        if (ctrl_ok) begin
            // Software may clear the flag; only software ever does
            nxt_fail = wd_ff[`CSFM_BIT_FAIL];
            if (!req_ff) begin
                nxt_new_source_select = wd_ff[`CSFM_NEW_SOURCE_SELECT_LSB +: 3];
                if (wd_ff[`CSFM_BIT_REQ]) begin
                    nxt_req = 1'b1;
                end
            end
        end
        if (fail_ev) begin
            nxt_fail = 1'b1;
        end
        if (rd_status) begin
            nxt_st = 3'b000;
        end
        if (ctrl_wr && !unlocked) begin
            nxt_st[`CSFM_ST_DROP] = 1'b1;
        end
        if (fail_ev || (ctrl_ok && wd_ff[`CSFM_BIT_FAIL] && !fail_ff)) begin
            nxt_st[`CSFM_ST_FAIL] = 1'b1;
        end
        if (done_ev && req_ff) begin
            nxt_st[`CSFM_ST_DONE] = 1'b1;
        end
        if (rd_go) begin
            nxt_r  = 1'b1;
            nxt_rr = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
            unique case (s_axi_araddr)
                `CSFM_OFS_CTRL:   nxt_rd = {16'h0000, ctrl_view};
                `CSFM_OFS_STATUS: nxt_rd = {29'h0, st_ff};
                `CSFM_OFS_MASK:   nxt_rd = {29'h0, msk_ff};
                `CSFM_OFS_CURSRC: nxt_rd = {29'h0, cosc_ff};
                default:          nxt_rd = 32'h0000_0000;
            endcase
        end else if (r_ff && s_axi_rready) begin
            nxt_r = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff        <= 1'b0;
            awa_ff       <= 12'h000;
            w_ff         <= 1'b0;
            wd_ff        <= 32'h0000_0000;
            ws_ff        <= 4'h0;
            b_ff         <= 1'b0;
            br_ff        <= 2'b00;
            r_ff         <= 1'b0;
            rd_ff        <= 32'h0000_0000;
            rr_ff        <= 2'b00;
            fail_ff      <= 1'b0;
            req_ff       <= 1'b0;
            new_source_select_ff      <= 3'h0;
            cosc_ff      <= 3'h0;
            st_ff        <= 3'h0;
            msk_ff       <= 3'h0;
            mon_sync_ff  <= 2'b00;
            done_sync_ff <= 2'b00;
            mon_q_ff     <= 1'b0;
            done_q_ff    <= 1'b0;
            switch_cmd <= '0;
            osc_fail_trap <= 1'b0;
            irq <= 1'b0;
        end else begin
            aw_ff   <= nxt_aw;
            awa_ff  <= nxt_awa;
            w_ff    <= nxt_w;
            wd_ff   <= nxt_wd;
            ws_ff   <= nxt_ws;
            b_ff    <= nxt_b;
            br_ff   <= nxt_br;
            r_ff    <= nxt_r;
            rd_ff   <= nxt_rd;
            rr_ff   <= nxt_rr;
            fail_ff <= nxt_fail;
            req_ff  <= nxt_req;
            new_source_select_ff <= nxt_new_source_select;
            cosc_ff <= nxt_cosc;
            st_ff   <= nxt_st;
            msk_ff  <= nxt_msk;
            mon_sync_ff <= {mon_sync_ff[0], failsafe_clock_monitor};
            done_sync_ff <= {done_sync_ff[0], switch_done};
            mon_q_ff <= mon_sync_ff[1];
            done_q_ff <= done_sync_ff[1];
            switch_cmd <= '{req: nxt_req, src: nxt_new_source_select};
            osc_fail_trap <= nxt_fail;
            irq <= |(nxt_st & nxt_msk);
        end
    end
endmodule : csfm_top
`default_nettype wire

/* verilog/csfm_unlock.sv */
// Unlock sequence tracker: two key writes open a short write window
`timescale 1ns/1ns
`default_nettype none
`include "csfm_regs.svh"
module csfm_unlock
    import csfm_pkg::*;
#(
    parameter int WINDOW_CYC = `CSFM_UNLOCK_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        key_wr,
    input  wire logic [15:0] key_data,
    input  wire logic        ctrl_wr,
    output logic             unlocked
);
    csfm_lock_t  state_ff, nxt_state;
    logic [7:0]  cnt_ff, nxt_cnt;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        unique case (state_ff)
            csfm_idle: begin
                if (key_wr && key_data == `CSFM_UNLOCK_KEY1) begin
                    nxt_state = csfm_key1;
                end
            end
            csfm_key1: begin
                if (key_wr) begin
                    nxt_state = (key_data == `CSFM_UNLOCK_KEY2) ? csfm_open : csfm_idle;
                    nxt_cnt   = 8'(WINDOW_CYC);
                end else if (ctrl_wr) begin
                    nxt_state = csfm_idle;
                end
            end
            csfm_open: begin
                // Window closes on use, on a new key write or after a timeout
                if (ctrl_wr || key_wr || cnt_ff == 8'h00) begin
                    nxt_state = csfm_idle;
                end else begin
                    nxt_cnt = cnt_ff - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= csfm_idle;
            cnt_ff   <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    assign unlocked = (state_ff == csfm_open);
endmodule : csfm_unlock
`default_nettype wire
